//--- core/gptc_pkg.sv
// Package with constants for the capture/match timer
package gptc_pkg;
    localparam int CNT_W = 32;
    localparam int NCH = 4;
    // Counter modes
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EXT_RISE = 2'h1;
    localparam logic [1:0] MODE_EXT_FALL = 2'h2;
    localparam logic [1:0] MODE_EXT_BOTH = 2'h3;
    // External match output actions
    localparam logic [1:0] EMC_NONE = 2'h0;
    localparam logic [1:0] EMC_LOW = 2'h1;
    localparam logic [1:0] EMC_HIGH = 2'h2;
    localparam logic [1:0] EMC_TOGGLE = 2'h3;
    // Interrupt controller channels of the two timer instances
    localparam int IRQ_CHAN_TIMER0 = 4;
    localparam int IRQ_CHAN_TIMER1 = 5;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage

//--- core/gptc_timer.sv
// Timer/counter with prescaler, four capture and four match channels
// Functional notes
// - 32-bit up-counter advanced at a rate set by a 32-bit prescaler.
// - Counts either clock cycles or external events.
// - Four capture channels latch the count on input transitions.
// - A capture event may raise the interrupt when enabled.
// - Four match values compared; match may interrupt, counting continues.
// - A match may halt the counter, optionally interrupting.
// - A match may reset the counter to zero, optionally interrupting.
// - Four match outputs: low, high, toggle or unchanged on match.
// - Several pins may combine, by AND or OR, into one capture input.
// - Exactly one capture input is selectable as counting clock.
// - Other capture inputs stay usable while one counts.
// - All flags merge onto one request line per timer.
`timescale 1ns/1ps
module gptc_timer #(
    parameter int PINS_PER_CAP = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic count_enable,
    input wire logic count_reset,
    input wire logic [1:0] count_mode,
    input wire logic [1:0] count_source_sel,
    input wire logic [31:0] prescale_value,
    // Capture configuration, per channel
    input wire logic [3:0] cap_rise_en,
    input wire logic [3:0] cap_fall_en,
    input wire logic [3:0] cap_irq_en,
    input wire logic [3:0] cap_combine_and,
    input wire logic [4*PINS_PER_CAP-1:0] cap_pin_sel,
    // Match configuration, per channel
    input wire logic [31:0] match_value_0,
    input wire logic [31:0] match_value_1,
    input wire logic [31:0] match_value_2,
    input wire logic [31:0] match_value_3,
    input wire logic [3:0] match_irq_en,
    input wire logic [3:0] match_reset_en,
    input wire logic [3:0] match_stop_en,
    input wire logic [7:0] match_out_action,
    // Flag clear, one bit per flag: match 0..3 then capture 0..3
    input wire logic [7:0] flag_clear,
    // Pins
    input wire logic [4*PINS_PER_CAP-1:0] capture_input_pin,
    // Status and outputs
    output logic [31:0] count_value,
    output logic [31:0] prescale_count,
    output logic [31:0] capture_value_0,
    output logic [31:0] capture_value_1,
    output logic [31:0] capture_value_2,
    output logic [31:0] capture_value_3,
    output logic [7:0] irq_flags,
    output logic [3:0] match_out,
    output logic counter_running,
    output logic irq_req
);
    // Refuse pin groups that the select ports cannot serve
    if (PINS_PER_CAP < 1 || PINS_PER_CAP > 8) begin : g_bad_pins
        $error("PINS_PER_CAP out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4*PINS_PER_CAP-1:0] pin_s1;
        logic [4*PINS_PER_CAP-1:0] pin_s2;
        logic [3:0] cap_lvl;
        logic [31:0] tc;
        logic [31:0] pc;
        logic [3:0][31:0] cap;
        logic [7:0] flags;
        logic [3:0] emr;
        logic halt;
        logic run;
    } gptc_state_t;

    gptc_state_t state_reg;
    gptc_state_t state_next;

    // ------------------------------------------------------------
    // Pin combining per capture channel
    // ------------------------------------------------------------
    logic [3:0] cap_in;
    logic [3:0] cap_rise;
    logic [3:0] cap_fall;
    logic [3:0] cap_evt;
    logic [3:0][31:0] match_val;
    logic [3:0] match_hit;

    assign match_val = {match_value_3, match_value_2,
                        match_value_1, match_value_0};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            logic [PINS_PER_CAP-1:0] sel;
            logic [PINS_PER_CAP-1:0] lvl;
            assign sel = cap_pin_sel[g*PINS_PER_CAP +: PINS_PER_CAP];
            assign lvl = state_reg.pin_s2[g*PINS_PER_CAP +: PINS_PER_CAP];
            // AND of selected pins, or OR of selected pins
            assign cap_in[g] = cap_combine_and[g] ? &(lvl | ~sel)
                                                  : |(lvl & sel);
            assign cap_rise[g] = cap_in[g] & ~state_reg.cap_lvl[g];
            assign cap_fall[g] = ~cap_in[g] & state_reg.cap_lvl[g];
            // The counting input stays free for capture too
            assign cap_evt[g] = (cap_rise[g] & cap_rise_en[g])
                              | (cap_fall[g] & cap_fall_en[g]);
            assign match_hit[g] = state_reg.tc == match_val[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic tick;
    logic ext_edge;
    logic prescale_done;
    logic [1:0] sel_src;
    logic [7:0] set_flags;
    logic [3:0] match_evt;

    always_comb begin
        state_next = state_reg;
        sel_src = count_source_sel;
        state_next.pin_s1 = capture_input_pin;
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.cap_lvl = cap_in;
        // Count enable per mode: every cycle in timer mode, else an edge of the single selected capture input
        unique case (count_mode)
            gptc_pkg::MODE_TIMER: ext_edge = 1'b1;
            gptc_pkg::MODE_EXT_RISE: ext_edge = cap_rise[sel_src];
            gptc_pkg::MODE_EXT_FALL: ext_edge = cap_fall[sel_src];
            gptc_pkg::MODE_EXT_BOTH:
                ext_edge = cap_rise[sel_src] | cap_fall[sel_src];
        endcase
        tick = state_reg.run & ext_edge;
        prescale_done = state_reg.pc >= prescale_value;
        // Match events only on a count step, so one hit per value
        match_evt = (tick && prescale_done) ? match_hit : 4'h0;
        if (tick) begin
            if (prescale_done) begin
                state_next.pc = gptc_pkg::RESET_ZERO;
                state_next.tc = state_reg.tc + 32'h0000_0001;
            end else begin
                state_next.pc = state_reg.pc + 32'h0000_0001;
            end
        end
        if (|(match_evt & match_reset_en)) begin
            state_next.tc = gptc_pkg::RESET_ZERO;
            state_next.pc = gptc_pkg::RESET_ZERO;
        end
        // A stop on match holds until count_enable is dropped
        state_next.halt = state_reg.halt & count_enable;
        if (|(match_evt & match_stop_en)) begin
            state_next.halt = 1'b1;
        end
        state_next.run = count_enable & ~state_next.halt;
        if (count_reset) begin
            state_next.tc = gptc_pkg::RESET_ZERO;
            state_next.pc = gptc_pkg::RESET_ZERO;
        end
        for (int i = 0; i < 4; i++) begin
            if (cap_evt[i]) begin
                state_next.cap[i] = state_reg.tc;
            end
            if (match_evt[i]) begin
                unique case (match_out_action[2*i +: 2])
                    gptc_pkg::EMC_NONE: state_next.emr[i] = state_reg.emr[i];
                    gptc_pkg::EMC_LOW: state_next.emr[i] = 1'b0;
                    gptc_pkg::EMC_HIGH: state_next.emr[i] = 1'b1;
                    gptc_pkg::EMC_TOGGLE: state_next.emr[i] = ~state_reg.emr[i];
                endcase
            end
        end
        // Set wins over a clear in the same cycle
        set_flags = {cap_evt & cap_irq_en, match_evt & match_irq_en};
        state_next.flags = (state_reg.flags & ~flag_clear) | set_flags;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign count_value = state_reg.tc;
    assign prescale_count = state_reg.pc;
    assign capture_value_0 = state_reg.cap[0];
    assign capture_value_1 = state_reg.cap[1];
    assign capture_value_2 = state_reg.cap[2];
    assign capture_value_3 = state_reg.cap[3];
    assign irq_flags = state_reg.flags;
    assign match_out = state_reg.emr;
    assign counter_running = state_reg.run;
    assign irq_req = |state_reg.flags;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence step_s;
        tick && prescale_done && !count_reset && !(|(match_evt & match_reset_en));
    endsequence

    count_step_a: assert property (@(posedge clk) disable iff (!resetn)
        step_s |=> count_value == $past(count_value) + 32'h0000_0001)
        else $error("counter did not step");
    prescale_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
        (tick && prescale_done && !count_reset) |=> prescale_count == 32'h0)
        else $error("prescaler did not restart");
    timer_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        (!state_reg.run && !count_reset) |=> $stable(count_value))
        else $error("counter moved while stopped");
    capture_load_a: assert property (@(posedge clk) disable iff (!resetn)
        cap_evt[1] |=> capture_value_1 == $past(count_value))
        else $error("capture value wrong");
    capture_irq_a: assert property (@(posedge clk) disable iff (!resetn)
        (cap_evt[1] && cap_irq_en[1]) |=> irq_flags[5] ##0 irq_req)
        else $error("capture flag missing");
    match_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        |(match_evt & match_stop_en) |=> !counter_running)
        else $error("stop on match failed");
    match_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        |(match_evt & match_reset_en) |=> count_value == 32'h0)
        else $error("reset on match failed");
    match_toggle_a: assert property (@(posedge clk) disable iff (!resetn)
        (match_evt[1] && match_out_action[3:2] == gptc_pkg::EMC_TOGGLE)
        |=> match_out[1] != $past(match_out[1]))
        else $error("match output did not toggle");
    flag_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        (irq_flags[0] && !flag_clear[0]) |=> irq_flags[0])
        else $error("flag dropped without clear");
endmodule

//--- verif/gptc_pin_model.sv
// Pin-side model that drives the timer's capture pins
`timescale 1ns/1ps
module gptc_pin_model (
    // Clock
    input wire logic clk,
    // Pins
    output logic [7:0] pins
);
    initial pins = 8'h00;
    // Pulses the masked pins n times: two cycles high, then two cycles low (three between pulses)
    task automatic burst(input logic [7:0] mask, input int n);
        repeat (n) begin
            @(posedge clk);
            pins <= pins | mask;
            repeat (2) @(posedge clk);
            pins <= pins & ~mask;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

//--- verif/test_general_purpose_timer_capture_match.sv
// Self-checking bench for the capture/match timer
`timescale 1ns/1ps
module test_general_purpose_timer_capture_match;
    typedef struct {logic [3:0] sel; logic [31:0] exp;} gptc_note_t;
    logic clk, resetn, count_enable, count_reset, counter_running, irq_req;
    logic [1:0] count_mode, count_source_sel;
    logic [31:0] prescale_value, mv0, mv1, mv2, mv3, cnt, cap1, cap3;
    logic [3:0] cap_rise_en, cap_fall_en, cap_irq_en, cap_combine_and;
    logic [3:0] match_irq_en, match_reset_en, match_stop_en, match_out;
    logic [7:0] cap_pin_sel, match_out_action, flag_clear, pins, irq_flags;
    logic [31:0] rnd, mval, cap0, cap2, pcnt;
    int failures = 0, comparisons = 0, cycles = 0;
    gptc_note_t notes[$];
    event look;

    gptc_timer gptc_timer_inst (.clk(clk), .resetn(resetn),
        .count_enable(count_enable), .count_reset(count_reset),
        .count_mode(count_mode), .count_source_sel(count_source_sel),
        .prescale_value(prescale_value), .cap_rise_en(cap_rise_en),
        .cap_fall_en(cap_fall_en), .cap_irq_en(cap_irq_en),
        .cap_combine_and(cap_combine_and), .cap_pin_sel(cap_pin_sel),
        .match_value_0(mv0), .match_value_1(mv1), .match_value_2(mv2),
        .match_value_3(mv3), .match_irq_en(match_irq_en),
        .match_reset_en(match_reset_en), .match_stop_en(match_stop_en),
        .match_out_action(match_out_action), .flag_clear(flag_clear),
        .capture_input_pin(pins), .count_value(cnt), .prescale_count(pcnt),
        .capture_value_0(cap0), .capture_value_1(cap1), .capture_value_2(cap2),
        .capture_value_3(cap3), .irq_flags(irq_flags),
        .match_out(match_out), .counter_running(counter_running),
        .irq_req(irq_req));
    gptc_pin_model gptc_pin_model_inst (.clk(clk), .pins(pins));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] seen(input logic [3:0] s);
        case (s)
            4'h0: return cnt;
            4'h1: return {24'h0, irq_flags};
            4'h2: return {28'h0, match_out};
            4'h3: return {30'h0, irq_req, counter_running};
            4'h4: return cap1;
            4'h5: return {31'h0, cnt <= mval};
            4'h6: return cap3;
            4'h7: return pcnt;
            4'h8: return cap0;
            default: return cap2;
        endcase
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic note(input logic [3:0] s, input logic [31:0] e);
        notes.push_back('{s, e});
        -> look;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Clears count and flags, then starts counting at the next edge
    task automatic restart(input logic [31:0] pre);
        @(posedge clk);
        count_enable <= 1'b0;
        count_reset <= 1'b1;
        flag_clear <= 8'hff;
        prescale_value <= pre;
        @(posedge clk);
        count_reset <= 1'b0;
        flag_clear <= 8'h00;
        count_enable <= 1'b1;
    endtask
    task automatic conclude;
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watcher, timeout and stimulus
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial forever begin
        @(look);
        while (notes.size() > 0)
            check(seen(notes[0].sel), notes.pop_front().exp);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        {resetn, count_enable, count_reset, count_mode} = '0;
        {count_source_sel, prescale_value, mval} = '0;
        {mv0, mv1, mv2, mv3} = {4{32'hffff_ffff}};
        {cap_rise_en, cap_fall_en, cap_irq_en, cap_combine_and} = '0;
        {match_irq_en, match_reset_en, match_stop_en} = '0;
        {cap_pin_sel, match_out_action, flag_clear} = '0;
        rnd = xs(32'h6374065a);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        restart(32'h2);
        tick(32);
        note(4'h0, 32'ha);
        note(4'h7, 32'h1);
        mval = 32'h4 + {29'h0, rnd[2:0]};
        @(posedge clk);
        {mv0, mv1} <= {mval, mval};
        {match_reset_en, match_irq_en, match_out_action} <= 16'h110e;
        restart(32'h0);
        tick(mval + 4);
        note(4'h1, 32'h1);
        note(4'h2, 32'h3);
        note(4'h3, 32'h3);
        note(4'h5, 32'h1);
        @(posedge clk);
        flag_clear <= 8'h01;
        @(posedge clk);
        flag_clear <= 8'h00;
        tick(0);
        note(4'h3, 32'h1);
        @(posedge clk);
        {mv0, mv1, mv2} <= {32'hffff_ffff, 32'hffff_ffff, 32'h6};
        {match_reset_en, match_stop_en, match_irq_en} <= 12'h044;
        match_out_action <= 8'h10;
        count_enable <= 1'b0;
        restart(32'h0);
        tick(30);
        note(4'h0, 32'h7);
        note(4'h1, 32'h4);
        note(4'h3, 32'h2);
        @(posedge clk);
        {cap_pin_sel, cap_combine_and, cap_rise_en} <= 16'hc48a;
        {cap_irq_en, flag_clear} <= 12'h2ff;
        @(posedge clk);
        flag_clear <= 8'h00;
        gptc_pin_model_inst.burst(8'h40, 1);
        gptc_pin_model_inst.burst(8'h04, 1);
        tick(6);
        note(4'h4, 32'h7);
        note(4'h6, 32'h0);
        gptc_pin_model_inst.burst(8'hc0, 1);
        tick(6);
        note(4'h6, 32'h7);
        note(4'h1, 32'h20);
        for (int ch = 0; ch < 4; ch++) begin
            @(posedge clk);
            {mv2, match_stop_en, cap_rise_en} <= {32'hffff_ffff, 8'h0f};
            {cap_pin_sel, cap_combine_and, cap_irq_en} <= 16'h5500;
            count_mode <= 2'(ch % 3 + 1);
            count_source_sel <= 2'(ch);
            restart(32'h0);
            gptc_pin_model_inst.burst(8'h55 ^ (8'h01 << (2 * ch)), 2);
            gptc_pin_model_inst.burst(8'h01 << (2 * ch), 3);
            tick(6);
            note(4'h0, (ch % 3 == 2) ? 32'h6 : 32'h3);
            note((ch == 0) ? 4'h8 : (ch == 1) ? 4'h4 : (ch == 2) ? 4'h9 : 4'h6,
                (ch == 2) ? 32'h4 : 32'h2);
        end
        tick(2);
        conclude();
    end
endmodule
